// File: design/eer_pkg.sv
package eer_pkg;

	localparam logic [11:0] EER_OFS_STATUS = 12'h718;
	localparam logic [11:0] EER_OFS_MASK = 12'h71c;
	localparam logic [11:0] EER_OFS_CTRL = 12'h720;

	// station error bits: 0-2, 6-8, 12-14, 18-20
	localparam logic [31:0] EER_STN_BITS = 32'h001c_71c7;
	// factory-test bits kept writable but never set by hardware
	localparam logic [31:0] EER_FT_STATUS_BITS = 32'h0003_8e38;
	localparam logic [31:0] EER_STATUS_RST = 32'h0000_0000;
	localparam logic [31:0] EER_MASK_RST = 32'h001c_71c7;
	localparam logic [31:0] EER_MASK_WR_BITS = 32'h001f_ffff;

	localparam int EER_CTL_DIS1 = 0;
	localparam int EER_CTL_DIS2 = 1;
	localparam int EER_CTL_FORCE = 2;
	localparam int EER_CTL_NP = 3;
	localparam int EER_CTL_HP_PIN = 4;
	localparam int EER_CTL_NTL_PIN = 5;
	localparam int EER_CTL_GPIO_PIN = 6;
	localparam int EER_CTL_NTV_PIN = 7;
	localparam logic [31:0] EER_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] EER_CTRL_WR_BITS = 32'h0000_00ff;

	localparam int EER_NSTN = 3;
	localparam int EER_NINST = 4;
	localparam int EER_FEP_W = 5;
	localparam logic [4:0] EER_FEP_NONE = 5'h1f;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} eer_cfg_req_s;

	// interrupt sources needing routing
	typedef struct packed {
		logic hotplug;
		logic ntl_corr;
		logic ntl_uncorr;
		logic ntl_dll;
		logic ntl_errmsg;
		logic gpio;
		logic ntv_doorbell;
	} eer_irq_src_s;

	typedef struct packed {
		logic base_pin;
		logic vs_pin;
		logic intx;
	} eer_irq_out_s;

	// one ecc check result, per egress read of an ingress station ram
	typedef struct packed {
		logic valid;
		logic [1:0] src_stn;
		logic [1:0] inst;
		logic single;
		logic dbl;
	} eer_ecc_evt_s;

	function automatic logic [4:0] eer_stn_bit(input logic [1:0] stn, input logic [1:0] inst);
		eer_stn_bit = 5'(6 * int'(inst) + int'(stn));
	endfunction : eer_stn_bit

	function automatic logic [4:0] eer_first_set(input logic [31:0] v);
		eer_first_set = EER_FEP_NONE;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				eer_first_set = 5'(i);
			end
		end
	endfunction : eer_first_set

endpackage : eer_pkg

// File: design/eer_irq_route.sv
`timescale 1ns/1ps
module eer_irq_route import eer_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// configuration
	input wire logic [31:0] ctrl,
	input wire logic nt_mode,
	input wire logic nt_port,
	input wire logic vs_mode,
	// sources and outputs
	input eer_irq_src_s src,
	output eer_irq_out_s out
);

	typedef struct packed {
		eer_irq_out_s o;
	} eer_route_state_s;

	eer_route_state_s st_reg;
	eer_route_state_s st_next;
	logic nt_ok;
	logic pin_req;
	logic msg_req;
	logic ntl_any;

	always_comb begin
		nt_ok = nt_mode && nt_port;
		ntl_any = src.ntl_corr | src.ntl_uncorr | src.ntl_dll | src.ntl_errmsg;
		pin_req = 1'b0;
		msg_req = 1'b0;
		if (src.hotplug) begin
			if (ctrl[EER_CTL_HP_PIN]) pin_req = 1'b1; else msg_req = 1'b1;
		end
		if (ntl_any && nt_ok) begin
			if (ctrl[EER_CTL_NTL_PIN]) pin_req = 1'b1; else msg_req = 1'b1;
		end
		if (src.gpio) begin
			if (ctrl[EER_CTL_GPIO_PIN]) pin_req = 1'b1; else msg_req = 1'b1;
		end
		if (src.ntv_doorbell && nt_ok) begin
			if (ctrl[EER_CTL_NTV_PIN]) pin_req = 1'b1; else msg_req = 1'b1;
		end
		st_next.o.base_pin = pin_req && !vs_mode;
		st_next.o.vs_pin = pin_req && vs_mode;
		st_next.o.intx = msg_req;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign out = st_reg.o;

endmodule : eer_irq_route

// File: design/eer_ecc_error_report.sv
`timescale 1ns/1ps
// Overview of operation
// - per-station double-bit ECC status bits at 0-2, 6-8, 12-14, 18-20.
// - status bits sticky, default zero, cleared by writing one; 31:24 read zero.
// - mask register bits correspond one-for-one to status bits.
// - mask zero has no effect; mask one suppresses that error indication.
// - station mask bits reset to one; mask bits sticky read-write.
// - control bit 0 set disables single-bit ECC checking.
// - control bit 1 set disables double-bit ECC checking.
// - force enable bit 2 makes error status registers plain read-write on transparent downstream ports only.
// - forcing first uncorrectable bit updates first-error pointer, header log untouched.
// - bit 3 selects forced errors as posted or non-posted.
// - bit 4 routes hot-plug interrupts to pin or INTx.
// - bit 5 routes link-side events in non-transparent mode only.
// - link-side events are correctable, uncorrectable, DLL change, error message.
// - bit 6 routes GPIO interrupts to pin or INTx.
// - bit 7 routes virtual-side doorbells in non-transparent mode only.
// - shared pin in base mode, per-switch pin in virtual switch mode.
// - egress flags error in bit of the ingress station whose ram was read.
// - unmasked error sends fatal/non-fatal message if internal status and enables allow.
module eer_ecc_error_report import eer_pkg::*; (
	// clock and resets
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hot_rst,
	// configuration access
	input eer_cfg_req_s cfg,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	// serial eeprom / i2c load
	input wire logic ld_valid,
	input wire logic [11:0] ld_addr,
	input wire logic [31:0] ld_data,
	// port configuration
	input wire logic nt_mode,
	input wire logic nt_port,
	input wire logic vs_mode,
	input wire logic transp_dn,
	input wire logic fatal_rep_en,
	input wire logic nonfatal_rep_en,
	input wire logic err_is_fatal,
	// ecc events from egress reads
	input eer_ecc_evt_s ecc_evt,
	// interrupt sources
	input eer_irq_src_s irq_src,
	// uncorrectable/correctable status access
	input wire logic [31:0] aer_uncorr_wr,
	input wire logic aer_uncorr_we,
	input wire logic [31:0] aer_corr_wr,
	input wire logic aer_corr_we,
	// results
	output logic single_chk_en,
	output logic double_chk_en,
	output logic [31:0] aer_uncorr,
	output logic [31:0] aer_corr,
	output logic [4:0] first_err_ptr,
	output logic hdr_log_we,
	output logic forced_np,
	output logic err_fatal_msg,
	output logic err_nonfatal_msg,
	output eer_irq_out_s irq_out
);

	typedef struct packed {
		logic [31:0] status;
		logic [31:0] mask;
		logic [31:0] ctrl;
		logic [31:0] uncorr;
		logic [31:0] corr;
		logic [4:0] fep;
		logic hlog;
		logic [31:0] rdata;
		logic rvalid;
		logic fmsg;
		logic nfmsg;
		logic [31:0] pend;
	} eer_state_s;

	eer_state_s st_reg;
	eer_state_s st_next;
	logic [31:0] set_bits;
	logic [31:0] ctrl_wmask;
	logic [31:0] new_err;
	logic force_on;

	function automatic logic [31:0] eer_w1c(input logic [31:0] cur, input logic [31:0] wr,
			input logic [31:0] set);
		eer_w1c = (cur & ~wr) | set;
	endfunction : eer_w1c

	always_comb begin
		st_next = st_reg;
		set_bits = '0;
		ctrl_wmask = EER_CTRL_WR_BITS;
		if (!transp_dn) ctrl_wmask[EER_CTL_FORCE] = 1'b0;
		if (!nt_port) begin
			ctrl_wmask[EER_CTL_NTL_PIN] = 1'b0;
			ctrl_wmask[EER_CTL_NTV_PIN] = 1'b0;
		end
		force_on = st_reg.ctrl[EER_CTL_FORCE] && transp_dn;

		// egress check of ingress ram; flag in the ingress station bit
		if (ecc_evt.valid && ecc_evt.dbl && !st_reg.ctrl[EER_CTL_DIS2]
				&& ecc_evt.src_stn < 2'(EER_NSTN)) begin
			set_bits[eer_stn_bit(ecc_evt.src_stn, ecc_evt.inst)] = 1'b1;
		end

		// status: sticky w1c, set wins over clear
		if (cfg.wr && cfg.addr == EER_OFS_STATUS) begin
			st_next.status = eer_w1c(st_reg.status, cfg.wdata & (EER_STN_BITS
				| EER_FT_STATUS_BITS), set_bits);
		end else begin
			st_next.status = st_reg.status | set_bits;
		end

		if (cfg.wr && cfg.addr == EER_OFS_MASK) begin
			st_next.mask = cfg.wdata & EER_MASK_WR_BITS;
		end
		if (cfg.wr && cfg.addr == EER_OFS_CTRL) begin
			st_next.ctrl = cfg.wdata & ctrl_wmask;
		end

		// serial configuration load of sticky bits
		if (ld_valid) begin
			if (ld_addr == EER_OFS_STATUS) begin
				st_next.status = (ld_data & (EER_STN_BITS | EER_FT_STATUS_BITS))
					| set_bits;
			end else if (ld_addr == EER_OFS_MASK) begin
				st_next.mask = ld_data & EER_MASK_WR_BITS;
			end else if (ld_addr == EER_OFS_CTRL) begin
				st_next.ctrl = ld_data & ctrl_wmask;
			end
		end

		// error status registers: rw when forced, else w1c
		st_next.hlog = 1'b0;
		if (aer_uncorr_we) begin
			if (force_on) begin
				st_next.uncorr = aer_uncorr_wr;
				if (st_reg.uncorr == '0 && aer_uncorr_wr != '0) begin
					st_next.fep = eer_first_set(aer_uncorr_wr);
				end
			end else begin
				st_next.uncorr = st_reg.uncorr & ~aer_uncorr_wr;
			end
		end
		if (aer_corr_we) begin
			if (force_on) begin
				st_next.corr = aer_corr_wr;
			end else begin
				st_next.corr = st_reg.corr & ~aer_corr_wr;
			end
		end

		// unmasked new errors become pending messages
		new_err = set_bits & ~st_reg.mask;
		st_next.pend = (st_reg.pend | new_err) & ~st_reg.mask;
		st_next.fmsg = 1'b0;
		st_next.nfmsg = 1'b0;
		if (st_reg.pend != '0 && st_reg.uncorr[22]) begin
			if (err_is_fatal && fatal_rep_en) st_next.fmsg = 1'b1;
			if (!err_is_fatal && nonfatal_rep_en) st_next.nfmsg = 1'b1;
			st_next.pend = new_err;
		end
		if (new_err != '0) begin
			st_next.uncorr[22] = 1'b1;
			if (st_reg.uncorr == '0) st_next.fep = 5'd22;
		end

		// register read
		st_next.rvalid = cfg.rd;
		if (cfg.rd) begin
			if (cfg.addr == EER_OFS_STATUS) begin
				st_next.rdata = st_reg.status;
			end else if (cfg.addr == EER_OFS_MASK) begin
				st_next.rdata = st_reg.mask;
			end else if (cfg.addr == EER_OFS_CTRL) begin
				st_next.rdata = st_reg.ctrl;
			end else begin
				st_next.rdata = '0;
			end
		end
	end

	// sticky registers keep value across hot reset; only sys_rst clears them
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.status <= EER_STATUS_RST;
			st_reg.mask <= EER_MASK_RST;
			st_reg.ctrl <= EER_CTRL_RST;
			st_reg.fep <= EER_FEP_NONE;
		end else if (hot_rst) begin
			st_reg.rdata <= '0;
			st_reg.rvalid <= 1'b0;
			st_reg.fmsg <= 1'b0;
			st_reg.nfmsg <= 1'b0;
			st_reg.pend <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	eer_irq_route u_route (
		.clk(clk),
		.sys_rst(sys_rst),
		.ctrl(st_reg.ctrl),
		.nt_mode(nt_mode),
		.nt_port(nt_port),
		.vs_mode(vs_mode),
		.src(irq_src),
		.out(irq_out)
	);

	assign cfg_rdata = st_reg.rdata;
	assign cfg_rvalid = st_reg.rvalid;
	assign single_chk_en = !st_reg.ctrl[EER_CTL_DIS1];
	assign double_chk_en = !st_reg.ctrl[EER_CTL_DIS2];
	assign aer_uncorr = st_reg.uncorr;
	assign aer_corr = st_reg.corr;
	assign first_err_ptr = st_reg.fep;
	assign hdr_log_we = st_reg.hlog;
	assign forced_np = st_reg.ctrl[EER_CTL_NP];
	assign err_fatal_msg = st_reg.fmsg;
	assign err_nonfatal_msg = st_reg.nfmsg;

endmodule : eer_ecc_error_report

// File: verif/eer_ecc_error_report_properties.sv
`timescale 1ns/1ps
module eer_ecc_error_report_properties import eer_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// watched ports
	input eer_cfg_req_s cfg,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rvalid,
	input wire logic vs_mode,
	input wire logic single_chk_en,
	input wire logic double_chk_en,
	input wire logic forced_np,
	input wire logic hdr_log_we,
	input wire logic [31:0] aer_uncorr,
	input wire logic [4:0] first_err_ptr,
	input wire logic err_fatal_msg,
	input eer_irq_out_s irq_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_rd_ctrl;
		cfg.rd && cfg.addr == EER_OFS_CTRL ##1 cfg_rvalid;
	endsequence
	sequence s_rd_status;
		cfg.rd && cfg.addr == EER_OFS_STATUS;
	endsequence
	chk_read_answer: assert property (cfg.rd |=> cfg_rvalid)
		else $error("read not answered");
	chk_status_upper_zero: assert property (s_rd_status |=> cfg_rdata[31:24] == 8'h00)
		else $error("status upper bits set");
	chk_single_check_en: assert property (s_rd_ctrl |-> single_chk_en == !cfg_rdata[0])
		else $error("single check enable wrong");
	chk_double_check_en: assert property (s_rd_ctrl |-> double_chk_en == !cfg_rdata[1])
		else $error("double check enable wrong");
	chk_forced_np_sel: assert property (s_rd_ctrl |-> forced_np == cfg_rdata[3])
		else $error("forced np select wrong");
	chk_header_log_kept: assert property (hdr_log_we == 1'b0)
		else $error("header log written");
	chk_base_pin_mode: assert property (irq_out.base_pin |-> !$past(vs_mode))
		else $error("base pin in switch mode");
	chk_vs_pin_mode: assert property (irq_out.vs_pin |-> $past(vs_mode))
		else $error("switch pin in base mode");
	chk_msg_needs_internal: assert property (err_fatal_msg |-> $past(aer_uncorr[22]))
		else $error("message without internal error");
	chk_reset_values: assert property ($past(sys_rst) |-> first_err_ptr == 5'h1f)
		else $error("pointer reset value wrong");
endmodule : eer_ecc_error_report_properties

bind eer_ecc_error_report eer_ecc_error_report_properties chk (.clk, .sys_rst, .cfg,
	.cfg_rdata, .cfg_rvalid, .vs_mode, .single_chk_en, .double_chk_en, .forced_np,
	.hdr_log_we, .aer_uncorr, .first_err_ptr, .err_fatal_msg, .irq_out);

// File: verif/eer_irq_host.sv
`timescale 1ns/1ps
module eer_irq_host import eer_pkg::*; (
	// clock
	input wire logic clk,
	// device interrupt outputs
	input eer_irq_out_s irq,
	// seen traffic
	output int pin_cnt,
	output int msg_cnt
);
	// one driver per count: the counters live here, the ports only mirror them
	int pin_q = 0;
	int msg_q = 0;
	always @(posedge clk) begin
		if (irq.base_pin || irq.vs_pin) begin
			pin_q <= pin_q + 1;
		end
		if (irq.intx) begin
			msg_q <= msg_q + 1;
		end
	end
	assign pin_cnt = pin_q;
	assign msg_cnt = msg_q;
endmodule : eer_irq_host

// File: verif/eer_ecc_error_report_tb.sv
`timescale 1ns/1ps
module eer_ecc_error_report_tb import eer_pkg::*;;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hot_rst = 1'b0;
	eer_cfg_req_s cfg = '0;
	logic [31:0] cfg_rdata, aer_uncorr, aer_corr, e;
	logic cfg_rvalid, single_chk_en, double_chk_en, hdr_log_we, forced_np;
	logic err_fatal_msg, err_nonfatal_msg, p, v, u, f;
	logic ld_valid = 1'b0;
	logic [11:0] ld_addr = EER_OFS_MASK;
	logic [31:0] ld_data = '0, aer_uncorr_wr = '0, aer_corr_wr = '0;
	logic aer_uncorr_we = 1'b0, aer_corr_we = 1'b0;
	logic nt_mode = 1'b1, nt_port = 1'b1, vs_mode = 1'b0, transp_dn = 1'b1;
	logic fatal_rep_en = 1'b1, nonfatal_rep_en = 1'b1, err_is_fatal = 1'b1;
	logic [4:0] first_err_ptr;
	eer_ecc_evt_s ecc_evt = '0;
	eer_irq_src_s irq_src = '0;
	eer_irq_out_s irq_out;
	int pin_cnt, msg_cnt, s, n;
	int failures = 0;
	int comparisons = 0;
	int cb[4] = '{EER_CTL_HP_PIN, EER_CTL_NTL_PIN, EER_CTL_GPIO_PIN, EER_CTL_NTV_PIN};
	eer_irq_src_s sm[4] = '{7'h40, 7'h3c, 7'h02, 7'h01};

	always #4 clk = ~clk;

	eer_ecc_error_report DUT (.clk, .sys_rst, .hot_rst, .cfg, .cfg_rdata, .cfg_rvalid,
		.ld_valid, .ld_addr, .ld_data, .nt_mode, .nt_port, .vs_mode, .transp_dn,
		.fatal_rep_en, .nonfatal_rep_en, .err_is_fatal, .ecc_evt, .irq_src,
		.aer_uncorr_wr, .aer_uncorr_we, .aer_corr_wr, .aer_corr_we, .single_chk_en,
		.double_chk_en, .aer_uncorr, .aer_corr, .first_err_ptr, .hdr_log_we, .forced_np,
		.err_fatal_msg, .err_nonfatal_msg, .irq_out);
	eer_irq_host host (.clk, .irq(irq_out), .pin_cnt, .msg_cnt);

	function automatic logic [31:0] sbit(input int st, input int inst);
		return 32'h1 << (6 * inst + st);
	endfunction : sbit

	task check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk) cfg <= '{1'b1, 1'b0, a, d};
		@(posedge clk) cfg <= '0;
	endtask : wr

	task rdc(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk) cfg <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk) cfg <= '0;
		@(negedge clk) check(cfg_rdata, exp);
	endtask : rdc

	task evt(input int st, input int inst);
		@(posedge clk) ecc_evt <= '{1'b1, 2'(st), 2'(inst), 1'b0, 1'b1};
		@(posedge clk) ecc_evt <= '0;
		@(negedge clk);
	endtask : evt

	task aerw(input logic [31:0] u, input logic [31:0] c);
		@(posedge clk) begin
			aer_uncorr_wr <= u;
			aer_corr_wr <= c;
			aer_uncorr_we <= 1'b1;
			aer_corr_we <= 1'b1;
		end
		@(posedge clk) begin
			aer_uncorr_we <= 1'b0;
			aer_corr_we <= 1'b0;
		end
		@(negedge clk);
	endtask : aerw

	task conclude;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	initial begin
		e = $urandom(78);
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rdc(EER_OFS_STATUS, EER_STATUS_RST);
		rdc(EER_OFS_MASK, EER_MASK_RST);
		rdc(EER_OFS_CTRL, EER_CTRL_RST);
		rdc(12'h724, 32'h0);
		wr(EER_OFS_CTRL, 32'h4);
		n = $urandom_range(20);
		e = $urandom;
		aerw(sbit(n, 0), e);
		check(aer_uncorr, sbit(n, 0));
		check(aer_corr, e);
		check({27'h0, first_err_ptr}, 32'(n));
		aerw('0, '0);
		wr(EER_OFS_CTRL, 32'h0);
		evt(0, 0);
		check({31'h0, aer_uncorr[22]}, 32'h0);
		wr(EER_OFS_STATUS, 32'h1);
		repeat (4) begin
			e = $urandom;
			p = 1'($urandom_range(1));
			@(posedge clk) begin
				transp_dn <= p;
				nt_port <= p;
			end
			wr(EER_OFS_CTRL, e);
			rdc(EER_OFS_CTRL, e & (p ? 32'hff : 32'h5b));
			check({29'h0, single_chk_en, double_chk_en, forced_np}, {29'h0, ~e[0], ~e[1], e[3]});
		end
		e = $urandom;
		@(posedge clk) begin
			ld_valid <= 1'b1;
			ld_data <= e;
		end
		@(posedge clk) ld_valid <= 1'b0;
		@(posedge clk) hot_rst <= 1'b1;
		@(posedge clk) hot_rst <= 1'b0;
		rdc(EER_OFS_MASK, e & EER_MASK_WR_BITS);
		wr(EER_OFS_MASK, 32'h0);
		repeat (6) begin
			s = $urandom_range(2);
			n = $urandom_range(3);
			p = 1'($urandom_range(1));
			f = 1'($urandom_range(1));
			u = 1'($urandom_range(1));
			@(posedge clk) begin
				err_is_fatal <= f;
				fatal_rep_en <= u;
				nonfatal_rep_en <= u;
			end
			wr(EER_OFS_CTRL, {30'h0, p, 1'b0});
			evt(s, n);
			// message pulse one cycle after the internal error bit and pending bit
			e = {30'h0, ~p & f & u, ~p & ~f & u};
			@(negedge clk) check({30'h0, err_fatal_msg, err_nonfatal_msg}, e);
			rdc(EER_OFS_STATUS, p ? 32'h0 : sbit(s, n));
			wr(EER_OFS_STATUS, sbit(s, n));
			rdc(EER_OFS_STATUS, 32'h0);
		end
		for (int i = 0; i < 8; i++) begin
			p = i[2];
			v = 1'($urandom_range(1));
			u = 1'($urandom_range(1));
			// link-side and doorbell sources only count in non-transparent mode
			f = u | ~i[0];
			@(posedge clk) begin
				vs_mode <= v;
				nt_mode <= u;
				nt_port <= 1'b1;
			end
			wr(EER_OFS_CTRL, 32'(p) << cb[i % 4]);
			@(posedge clk) irq_src <= sm[i % 4];
			repeat (3) @(negedge clk);
			e = {29'h0, p & ~v & f, p & v & f, ~p & f};
			check({29'h0, irq_out}, e);
			@(posedge clk) irq_src <= '0;
		end
		check({30'h0, pin_cnt > 0, msg_cnt > 0}, 32'h3);
		conclude();
	end

	initial begin
		#20000;
		failures++;
		conclude();
	end
endmodule : eer_ecc_error_report_tb
